// file: scf_pkg.sv
/*
  constants shared by the serial channel event block and its storage.
  assumes a single pclk domain and an APB3 register port with 32-bit data.
*/
package scf_pkg;

  // storage shape
  localparam int SCF_DEPTH = 8;
  localparam int SCF_AW = 3;
  localparam int SCF_CW = 4;
  localparam int SCF_DW = 9;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_AUTOBAUD_STATUS = 16'hF0B8;
  localparam logic [15:0] IDX_FIFO_STATUS = 16'hF0BA;
  localparam logic [15:0] IDX_TX_FIFO_CONTROL = 16'hF0C4;
  localparam logic [15:0] IDX_RX_FIFO_CONTROL = 16'hF0C6;
  localparam logic [15:0] IDX_AUTOBAUD_IRQ_CONTROL = 16'hF15C;
  localparam logic [15:0] IDX_TXBUF_IRQ_CONTROL = 16'hF19C;
  localparam logic [15:0] IDX_AUTOBAUD_CONTROL = 16'hF1B8;
  localparam logic [15:0] IDX_IRDA_PULSE_WIDTH = 16'hFEAA;
  localparam logic [15:0] IDX_TRANSMIT_BUFFER = 16'hFEB0;
  localparam logic [15:0] IDX_RECEIVE_BUFFER = 16'hFEB2;
  localparam logic [15:0] IDX_BAUD_TIMER_RELOAD = 16'hFEB4;
  localparam logic [15:0] IDX_FRACTIONAL_DIVIDER = 16'hFEB6;
  localparam logic [15:0] IDX_TRANSMIT_IRQ_CONTROL = 16'hFF6C;
  localparam logic [15:0] IDX_RECEIVE_IRQ_CONTROL = 16'hFF6E;
  localparam logic [15:0] IDX_ERROR_IRQ_CONTROL = 16'hFF70;
  localparam logic [15:0] IDX_CHANNEL_CONTROL = 16'hFFB0;
  localparam logic [15:0] IDX_EVENT_STATUS = 16'h0100;
  localparam logic [15:0] IDX_EVENT_MASK = 16'h0101;

  // channel_control fields
  localparam int CON_M_LSB = 0;
  localparam int CON_REN = 4;
  localparam int CON_PEN = 5;
  localparam int CON_FEN = 6;
  localparam int CON_OEN = 7;
  localparam int CON_PE = 8;
  localparam int CON_FE = 9;
  localparam int CON_OE = 10;
  localparam int CON_ODD = 12;

  // fifo control and status fields
  localparam int FCON_EN = 0;
  localparam int FCON_FLUSH = 1;
  localparam int FCON_TMEN = 2;
  localparam int FCON_LVL_LSB = 8;
  localparam int FSTAT_RX_LSB = 0;
  localparam int FSTAT_TX_LSB = 8;

  // event status bits
  localparam int EV_RX = 0;
  localparam int EV_ERR = 1;
  localparam int EV_TXB = 2;
  localparam int EV_N = 3;

  // operating modes
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_7_PARITY = 3'h3;
  localparam logic [2:0] MODE_8_PARITY = 3'h7;

  // reset values
  localparam logic [15:0] CON_RST = 16'h0000;
  localparam logic [15:0] FCON_RST = 16'h0100;
  localparam logic [EV_N-1:0] MASK_RST = 3'h0;

  // request lines stay active this many module clock cycles
  localparam logic [1:0] REQ_CYCLES = 2'h2;

endpackage

// file: scf_mem.sv
/*
  small word memory with one write port and a registered read port.
  assumes the caller keeps the read address steady for a cycle before using rdata.
*/
`timescale 1ns/100ps
module scf_mem #(
  parameter int W = 9,
  parameter int D = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem_r [D];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule

// file: scf_events.sv
/*
  serial channel fifo and event request logic with an APB register port.
  assumes the shifter logic on pclk delivers received frames and takes transmit words.
*/
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module scf_events (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive shifter side
  input wire logic rx_frame_valid,
  input wire logic [8:0] rx_frame_data,
  input wire logic rx_stop_ok,
  // transmit shifter side
  output logic [8:0] tx_data,
  output logic tx_data_valid,
  input wire logic tx_take,
  // request lines and interrupt
  output logic receive_request_line,
  output logic error_request_line,
  output logic txbuf_request_line,
  output logic irq
);

  localparam int AW = scf_pkg::SCF_AW;
  localparam int CW = scf_pkg::SCF_CW;

  logic [15:0] con_r;
  logic [15:0] rx_fcon_r;
  logic [15:0] tx_fcon_r;
  logic [scf_pkg::EV_N-1:0] ev_status_r;
  logic [scf_pkg::EV_N-1:0] ev_mask_r;
  logic ack_r;
  logic [AW-1:0] rx_wptr_r, rx_rptr_r, tx_wptr_r, tx_rptr_r;
  logic [CW-1:0] rx_cnt_r, tx_cnt_r;
  logic [8:0] rx_head, tx_head;

  // bus decode
  logic [15:0] idx;
  logic acc_done, wr_done, rd_done;
  logic [31:0] rd_word;
  logic rd_err;
  assign idx = paddr[17:2];
  assign acc_done = psel & penable & ack_r;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;
  assign pready = ack_r;

  logic wr_con, wr_rxf, wr_txf, wr_tbuf, wr_mask, rd_rbuf, rd_stat;
  assign wr_con = wr_done && idx == scf_pkg::IDX_CHANNEL_CONTROL;
  assign wr_rxf = wr_done && idx == scf_pkg::IDX_RX_FIFO_CONTROL;
  assign wr_txf = wr_done && idx == scf_pkg::IDX_TX_FIFO_CONTROL;
  assign wr_tbuf = wr_done && idx == scf_pkg::IDX_TRANSMIT_BUFFER;
  assign wr_mask = wr_done && idx == scf_pkg::IDX_EVENT_MASK;
  assign rd_rbuf = rd_done && idx == scf_pkg::IDX_RECEIVE_BUFFER;
  assign rd_stat = rd_done && idx == scf_pkg::IDX_EVENT_STATUS;

  // mode and fifo settings
  logic [2:0] mode;
  logic async_mode, rx_fen, rx_tm, tx_fen, tx_tm;
  logic [CW-1:0] rx_lvl, tx_lvl, rx_cap, tx_cap;
  assign mode = con_r[scf_pkg::CON_M_LSB +: 3];
  assign async_mode = mode != scf_pkg::MODE_SYNC;
  assign rx_fen = rx_fcon_r[scf_pkg::FCON_EN];
  assign rx_tm = rx_fcon_r[scf_pkg::FCON_TMEN];
  assign tx_fen = tx_fcon_r[scf_pkg::FCON_EN];
  assign tx_tm = tx_fcon_r[scf_pkg::FCON_TMEN];
  assign rx_lvl = rx_fcon_r[scf_pkg::FCON_LVL_LSB +: CW];
  assign tx_lvl = tx_fcon_r[scf_pkg::FCON_LVL_LSB +: CW];
  assign rx_cap = rx_fen ? CW'(scf_pkg::SCF_DEPTH) : CW'(1);
  assign tx_cap = tx_fen ? CW'(scf_pkg::SCF_DEPTH) : CW'(1);

  // receive fifo events
  logic rx_full, rx_push_new, rx_ovf, rx_pop, rx_empty_rd, rx_flush;
  assign rx_full = rx_cnt_r >= rx_cap;
  assign rx_ovf = rx_frame_valid & rx_full;
  assign rx_push_new = rx_frame_valid & ~rx_full;
  assign rx_pop = rd_rbuf & (rx_cnt_r != '0);
  assign rx_empty_rd = rd_rbuf & (rx_cnt_r == '0);
  assign rx_flush = wr_rxf & pwdata[scf_pkg::FCON_FLUSH];

  // transmit fifo events
  logic tx_full, tx_push_new, tx_ovf, tx_pop, tx_flush, tx_enable_ev;
  assign tx_full = tx_cnt_r >= tx_cap;
  assign tx_ovf = wr_tbuf & tx_full;
  assign tx_push_new = wr_tbuf & ~tx_full;
  assign tx_pop = tx_take & (tx_cnt_r != '0);
  assign tx_flush = wr_txf & pwdata[scf_pkg::FCON_FLUSH];
  assign tx_enable_ev = wr_txf & pwdata[scf_pkg::FCON_TMEN] & pwdata[scf_pkg::FCON_EN]
                      & tx_tm & ~tx_fen;

  // frame checks on received data
  logic par_mode, par_calc, par_got, par_bad, stop_bad;
  assign par_mode = mode == scf_pkg::MODE_7_PARITY || mode == scf_pkg::MODE_8_PARITY;
  assign par_calc = (mode == scf_pkg::MODE_7_PARITY) ? ^rx_frame_data[6:0] : ^rx_frame_data[7:0];
  assign par_got = (mode == scf_pkg::MODE_7_PARITY) ? rx_frame_data[7] : rx_frame_data[8];
  assign par_bad = rx_frame_valid & async_mode & par_mode
                 & ((par_calc ^ con_r[scf_pkg::CON_ODD]) != par_got);
  assign stop_bad = rx_frame_valid & async_mode & ~rx_stop_ok;

  // fill level after this cycle's push
  logic [CW-1:0] rx_cnt_after;
  assign rx_cnt_after = rx_cnt_r + CW'(1);

  // request causes, merged per line
  logic rx_level_ev, rx_tm_rd_ev;
  logic [scf_pkg::EV_N-1:0] trig;
  assign rx_level_ev = rx_push_new & ((rx_fen & ~rx_tm) ? (rx_cnt_after == rx_lvl) : 1'b1);
  assign rx_tm_rd_ev = rx_pop & rx_tm & (rx_cnt_r > CW'(1));
  assign trig[scf_pkg::EV_RX] = rx_level_ev | rx_ovf | rx_tm_rd_ev | stop_bad | par_bad;
  assign trig[scf_pkg::EV_ERR] = rx_ovf | rx_empty_rd | tx_ovf | stop_bad | par_bad;
  assign trig[scf_pkg::EV_TXB] = tx_flush | tx_enable_ev
                               | (tx_pop & ((tx_fen & ~tx_tm) ?
                                 (tx_cnt_r - CW'(1) == tx_lvl) : 1'b1));

  // two-cycle request stretchers
  logic [scf_pkg::EV_N-1:0] req;
  genvar g;
  for (g = 0; g < scf_pkg::EV_N; g++) begin : g_req
    logic [1:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= 2'h0;
      end else if (trig[g]) begin
        cnt_r <= scf_pkg::REQ_CYCLES;
      end else if (cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
    assign req[g] = cnt_r != 2'h0;
  end
  assign receive_request_line = req[scf_pkg::EV_RX];
  assign error_request_line = req[scf_pkg::EV_ERR];
  assign txbuf_request_line = req[scf_pkg::EV_TXB];

  // channel control with sticky fault flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_r <= scf_pkg::CON_RST;
    end else begin
      con_r <= wr_con ? pwdata[15:0] : con_r;
      if ((stop_bad & con_r[scf_pkg::CON_FEN]) | (wr_con & pwdata[scf_pkg::CON_FE])) begin
        con_r[scf_pkg::CON_FE] <= 1'b1;
      end
      if ((par_bad & con_r[scf_pkg::CON_PEN]) | (wr_con & pwdata[scf_pkg::CON_PE])) begin
        con_r[scf_pkg::CON_PE] <= 1'b1;
      end
      if (((rx_ovf | rx_empty_rd | tx_ovf) & con_r[scf_pkg::CON_OEN])
          | (wr_con & pwdata[scf_pkg::CON_OE])) begin
        con_r[scf_pkg::CON_OE] <= 1'b1;
      end
    end
  end

  // fifo control registers; flush bit is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fcon_r <= scf_pkg::FCON_RST;
      tx_fcon_r <= scf_pkg::FCON_RST;
    end else begin
      rx_fcon_r <= wr_rxf ? pwdata[15:0] & ~(16'h0001 << scf_pkg::FCON_FLUSH) : rx_fcon_r;
      tx_fcon_r <= wr_txf ? pwdata[15:0] & ~(16'h0001 << scf_pkg::FCON_FLUSH) : tx_fcon_r;
    end
  end

  // receive fifo pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wptr_r <= '0;
      rx_rptr_r <= '0;
      rx_cnt_r <= '0;
    end else if (rx_flush) begin
      rx_wptr_r <= '0;
      rx_rptr_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      rx_wptr_r <= rx_wptr_r + AW'(rx_push_new);
      rx_rptr_r <= rx_rptr_r + AW'(rx_pop);
      rx_cnt_r <= rx_cnt_r + CW'(rx_push_new) - CW'(rx_pop);
    end
  end

  // transmit fifo pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wptr_r <= '0;
      tx_rptr_r <= '0;
      tx_cnt_r <= '0;
    end else if (tx_flush) begin
      tx_wptr_r <= '0;
      tx_rptr_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      tx_wptr_r <= tx_wptr_r + AW'(tx_push_new);
      tx_rptr_r <= tx_rptr_r + AW'(tx_pop);
      tx_cnt_r <= tx_cnt_r + CW'(tx_push_new) - CW'(tx_pop);
    end
  end

  // storage; a frame on a full fifo lands on the newest entry
  scf_mem #(.W(scf_pkg::SCF_DW), .D(scf_pkg::SCF_DEPTH), .AW(AW)) u_rx_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(rx_frame_valid & ~rx_flush),
    .waddr(rx_full ? rx_wptr_r - AW'(1) : rx_wptr_r),
    .wdata(rx_frame_data),
    .raddr(rx_rptr_r),
    .rdata(rx_head)
  );

  scf_mem #(.W(scf_pkg::SCF_DW), .D(scf_pkg::SCF_DEPTH), .AW(AW)) u_tx_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_tbuf & ~tx_flush),
    .waddr(tx_full ? tx_wptr_r - AW'(1) : tx_wptr_r),
    .wdata(pwdata[8:0]),
    .raddr(tx_rptr_r),
    .rdata(tx_head)
  );

  assign tx_data = tx_head;
  assign tx_data_valid = tx_cnt_r != '0;

  // event status, cleared by reading it; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status_r <= '0;
      ev_mask_r <= scf_pkg::MASK_RST;
    end else begin
      ev_status_r <= (rd_stat ? '0 : ev_status_r) | trig;
      ev_mask_r <= wr_mask ? pwdata[scf_pkg::EV_N-1:0] : ev_mask_r;
    end
  end
  assign irq = |(ev_status_r & ev_mask_r);

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (idx)
      scf_pkg::IDX_CHANNEL_CONTROL: rd_word[15:0] = con_r;
      scf_pkg::IDX_RX_FIFO_CONTROL: rd_word[15:0] = rx_fcon_r;
      scf_pkg::IDX_TX_FIFO_CONTROL: rd_word[15:0] = tx_fcon_r;
      scf_pkg::IDX_RECEIVE_BUFFER: rd_word[8:0] = rx_head;
      scf_pkg::IDX_FIFO_STATUS: begin
        rd_word[scf_pkg::FSTAT_RX_LSB +: CW] = rx_cnt_r;
        rd_word[scf_pkg::FSTAT_TX_LSB +: CW] = tx_cnt_r;
      end
      scf_pkg::IDX_EVENT_STATUS: rd_word[scf_pkg::EV_N-1:0] = ev_status_r;
      scf_pkg::IDX_EVENT_MASK: rd_word[scf_pkg::EV_N-1:0] = ev_mask_r;
      scf_pkg::IDX_TRANSMIT_BUFFER, scf_pkg::IDX_AUTOBAUD_STATUS,
      scf_pkg::IDX_AUTOBAUD_IRQ_CONTROL, scf_pkg::IDX_TXBUF_IRQ_CONTROL,
      scf_pkg::IDX_AUTOBAUD_CONTROL, scf_pkg::IDX_IRDA_PULSE_WIDTH,
      scf_pkg::IDX_BAUD_TIMER_RELOAD, scf_pkg::IDX_FRACTIONAL_DIVIDER,
      scf_pkg::IDX_TRANSMIT_IRQ_CONTROL, scf_pkg::IDX_RECEIVE_IRQ_CONTROL,
      scf_pkg::IDX_ERROR_IRQ_CONTROL: rd_word = 32'h0000_0000;
      default: rd_err = 1'b1;
    endcase
    if (paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end
  end

  // one wait state: data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      ack_r <= psel & penable & ~ack_r;
      if (psel & penable & ~ack_r) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= rd_err;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_two_rx;
    receive_request_line ##1 receive_request_line;
  endsequence
  sequence s_quiet_err;
    !trig[scf_pkg::EV_ERR] ##1 !trig[scf_pkg::EV_ERR];
  endsequence

  property p_rx_width;
    trig[scf_pkg::EV_RX] |=> s_two_rx;
  endproperty
  a_rx_width: assert property (p_rx_width) else $error("rx request not two cycles");
  property p_err_end;
    s_quiet_err |=> !error_request_line;
  endproperty
  a_err_end: assert property (p_err_end) else $error("error request too long");
  property p_rx_async;
    rx_push_new && async_mode && !(rx_fen && !rx_tm) |=> s_two_rx;
  endproperty
  a_rx_async: assert property (p_rx_async) else $error("no rx request on frame");
  property p_rx_ovf;
    rx_ovf && !rx_pop && !rx_flush |=> receive_request_line && error_request_line
      && rx_cnt_r == $past(rx_cnt_r);
  endproperty
  a_rx_ovf: assert property (p_rx_ovf) else $error("rx overflow mishandled");
  property p_sync_ovr;
    rx_frame_valid && mode == scf_pkg::MODE_SYNC && rx_cnt_r != '0 && !rx_fen
      |=> error_request_line ##1 receive_request_line;
  endproperty
  a_sync_ovr: assert property (p_sync_ovr) else $error("sync overrun missed");
  property p_empty_rd;
    rx_empty_rd |=> error_request_line [*2];
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("empty read no error");
  property p_tm_rd;
    rx_pop && rx_tm && rx_cnt_r > CW'(1) |=> receive_request_line;
  endproperty
  a_tm_rd: assert property (p_tm_rd) else $error("transparent read no rx");
  property p_flush;
    tx_flush |=> txbuf_request_line && tx_cnt_r == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("flush no txbuf request");
  property p_tx_en;
    tx_enable_ev |=> txbuf_request_line ##1 txbuf_request_line && tx_fen;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("fifo enable no txbuf");
  property p_tx_ovf;
    tx_ovf && !tx_pop |=> error_request_line && tx_cnt_r == $past(tx_cnt_r);
  endproperty
  a_tx_ovf: assert property (p_tx_ovf) else $error("tx overflow mishandled");
  property p_frame;
    stop_bad && con_r[scf_pkg::CON_FEN] |=> con_r[scf_pkg::CON_FE]
      && receive_request_line && error_request_line;
  endproperty
  a_frame: assert property (p_frame) else $error("framing fault missed");
  property p_parity;
    par_bad |=> receive_request_line && error_request_line;
  endproperty
  a_parity: assert property (p_parity) else $error("parity fault missed");
  property p_sticky;
    con_r[scf_pkg::CON_FE] && !wr_con |=> con_r[scf_pkg::CON_FE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag dropped");

endmodule

// file: scf_remote.sv
/*
  far-side serial model: hands received frames to the event block and drains transmit words.
  assumes the bench calls send right after a rising edge and raises drain to accept words.
*/
`timescale 1ns/100ps
module scf_remote (
  // clock
  input wire logic pclk,
  // frames towards the block
  output logic rx_frame_valid,
  output logic [8:0] rx_frame_data,
  output logic rx_stop_ok,
  // words from the block
  input wire logic [8:0] tx_data,
  input wire logic tx_data_valid,
  output logic tx_take,
  input wire logic drain
);
  int taken = 0;
  int gap = 0;
  logic [8:0] last_tx = 9'h000;

  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_data = 9'h1FF;
    rx_stop_ok = 1'b0;
    tx_take = 1'b0;
  end

  // one frame per call; lines show the inverse once the frame is gone
  task automatic send(input logic [8:0] d, input logic stop);
    rx_frame_valid <= 1'b1;
    rx_frame_data <= d;
    rx_stop_ok <= stop;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
    rx_frame_data <= ~d;
    rx_stop_ok <= ~stop;
    repeat (3) @(posedge pclk);
  endtask

  // slow taker: head word needs two edges to follow a pop
  always @(posedge pclk) begin
    tx_take <= 1'b0;
    if (gap > 0) begin
      gap <= gap - 1;
    end else if (drain && tx_data_valid === 1'b1) begin
      tx_take <= 1'b1;
      last_tx <= tx_data;
      taken <= taken + 1;
      gap <= 4;
    end
  end
endmodule

// file: tb_top.sv
/*
  self-checking bench for the serial channel event block.
  assumes scf_pkg and scf_remote are compiled first; apb master on pclk.
*/
`timescale 1ns/100ps
module tb_top;
  localparam logic [15:0] A_CON = scf_pkg::IDX_CHANNEL_CONTROL;
  localparam logic [15:0] A_RXF = scf_pkg::IDX_RX_FIFO_CONTROL;
  localparam logic [15:0] A_TXF = scf_pkg::IDX_TX_FIFO_CONTROL;
  localparam logic [15:0] A_RB = scf_pkg::IDX_RECEIVE_BUFFER;
  localparam logic [15:0] A_TB = scf_pkg::IDX_TRANSMIT_BUFFER;
  localparam logic [15:0] A_ST = scf_pkg::IDX_EVENT_STATUS;
  localparam logic [15:0] A_MSK = scf_pkg::IDX_EVENT_MASK;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq, drain, e;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0] rxd, txd;
  logic rxv, rxs, txv, take, rreq, ereq, treq;
  int failures = 0;
  int compares = 0;
  int nr = 0, ne = 0, nt = 0;

  scf_events scf_events_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame_valid(rxv), .rx_frame_data(rxd), .rx_stop_ok(rxs),
    .tx_data(txd), .tx_data_valid(txv), .tx_take(take), .receive_request_line(rreq),
    .error_request_line(ereq), .txbuf_request_line(treq), .irq(irq));
  scf_remote scf_remote_i (.pclk(pclk), .rx_frame_valid(rxv), .rx_frame_data(rxd),
    .rx_stop_ok(rxs), .tx_data(txd), .tx_data_valid(txv), .tx_take(take), .drain(drain));

  always #5 pclk = ~pclk;

  // request cycles counted where outputs are settled
  always @(negedge pclk) begin
    if (rreq === 1'b1) nr++;
    if (ereq === 1'b1) ne++;
    if (treq === 1'b1) nt++;
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] m,
                    input logic [31:0] x);
    apb(1'b0, idx, 32'h0);
    chk(nm, x, q & m);
  endtask

  task automatic clr();
    nr = 0;
    ne = 0;
    nt = 0;
  endtask

  task automatic req(input string nm, input int r, input int er, input int t);
    repeat (4) @(posedge pclk);
    chk({nm, " rx"}, r, nr);
    chk({nm, " err"}, er, ne);
    chk({nm, " txb"}, t, nt);
    clr();
  endtask

  task automatic t_reset();
    rd("rx fifo control", A_RXF, 32'hFFFFFFFF, 32'h00000100);
    rd("channel control", A_CON, 32'hFFFFFFFF, 32'h00000000);
    rd("event mask", A_MSK, 32'hFFFFFFFF, 32'h00000000);
    apb(1'b0, 16'h0200, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask

  task automatic t_rx();
    wr(A_CON, 32'h000000F1);
    clr();
    scf_remote_i.send(9'h05A, 1'b1);
    req("async frame", 2, 0, 0);
    rd("async data", A_RB, 32'hFFFFFFFF, 32'h0000005A);
    wr(A_CON, 32'h00000090);
    scf_remote_i.send(9'h011, 1'b1);
    wr(A_CON, 32'h00000090);
    clr();
    scf_remote_i.send(9'h022, 1'b1);
    req("sync overrun", 2, 2, 0);
    rd("overrun flag", A_CON, 32'h00000400, 32'h00000400);
    apb(1'b0, A_RB, 32'h0);
    wr(A_CON, 32'h000000F1);
    wr(A_RXF, 32'h00000101);
    for (int i = 0; i < scf_pkg::SCF_DEPTH; i++) scf_remote_i.send(9'(16 + i), 1'b1);
    clr();
    scf_remote_i.send(9'h0AA, 1'b1);
    req("rx overflow", 2, 2, 0);
    for (int i = 0; i < scf_pkg::SCF_DEPTH; i++) begin
      rd("rx fifo data", A_RB, 32'h1FF, (i == 7) ? 32'hAA : 32'(16 + i));
    end
    $display("test receive done");
  endtask

  task automatic t_empty();
    wr(A_CON, 32'h000000F1);
    wr(A_MSK, 32'h7);
    apb(1'b0, A_ST, 32'h0);
    clr();
    apb(1'b0, A_RB, 32'h0);
    req("empty read", 0, 2, 0);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd("event status", A_ST, 32'h7, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd("empty flag", A_CON, 32'h400, 32'h400);
    wr(A_CON, 32'h000000F1);
    rd("flag cleared", A_CON, 32'h400, 32'h0);
    wr(A_MSK, 32'h5);
    apb(1'b0, A_RB, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd("masked status", A_ST, 32'h7, 32'h2);
    wr(A_RXF, 32'h00000105);
    scf_remote_i.send(9'h041, 1'b1);
    scf_remote_i.send(9'h042, 1'b1);
    clr();
    rd("transparent data", A_RB, 32'h1FF, 32'h41);
    req("transparent read", 2, 0, 0);
    rd("transparent last", A_RB, 32'h1FF, 32'h42);
    req("transparent empty", 0, 0, 0);
    $display("test empty done");
  endtask

  task automatic t_tx();
    int n;
    wr(A_TXF, 32'h00000101);
    clr();
    wr(A_TXF, 32'h00000103);
    req("flush", 0, 0, 2);
    wr(A_TXF, 32'h00000104);
    clr();
    wr(A_TXF, 32'h00000105);
    req("fifo enable", 0, 0, 2);
    wr(A_TXF, 32'h00000105);
    req("enable again", 0, 0, 0);
    for (int i = 0; i < scf_pkg::SCF_DEPTH; i++) wr(A_TB, 32'(256 + i));
    clr();
    wr(A_TB, 32'h000000EE);
    req("tx overflow", 0, 2, 0);
    drain <= 1'b1;
    for (n = 0; n < 400 && scf_remote_i.taken < 8; n++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk("tx words", 32'd8, scf_remote_i.taken);
    chk("last tx word", 32'hEE, {23'h0, scf_remote_i.last_tx});
    drain <= 1'b0;
    $display("test transmit done");
  endtask

  task automatic t_fault();
    wr(A_RXF, 32'h00000100);
    wr(A_CON, 32'h000000F1);
    clr();
    scf_remote_i.send(9'h033, 1'b0);
    req("framing", 2, 2, 0);
    rd("framing flag", A_CON, 32'h200, 32'h200);
    apb(1'b0, A_RB, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(A_CON, i ? 32'h000000F7 : 32'h000000F3);
      clr();
      scf_remote_i.send(9'h003, 1'b1);
      req("parity ok", 2, 0, 0);
      apb(1'b0, A_RB, 32'h0);
      clr();
      scf_remote_i.send(i ? 9'h103 : 9'h083, 1'b1);
      req("parity bad", 2, 2, 0);
      rd("parity flag", A_CON, 32'h100, 32'h100);
      apb(1'b0, A_RB, 32'h0);
    end
    clr();
    scf_remote_i.send(9'h103, 1'b0);
    req("merged faults", 2, 2, 0);
    $display("test fault done");
  endtask

  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    drain = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rx();
    t_empty();
    t_tx();
    t_fault();
    final_report();
  end
endmodule
